// *** pwk_pkg.sv ***
// Package of constants for the peripheral interrupt and wake-up logic.
package pwk_pkg;
	// ==========================================================
	// Source map
	localparam int PWK_NSRC = 5;
	localparam int PWK_IDXW = 3;
	localparam logic [2:0] SRC_SERIAL = 3'h0;
	localparam logic [2:0] SRC_TWOWIRE = 3'h1;
	localparam logic [2:0] SRC_DATAMEM = 3'h2;
	localparam logic [2:0] SRC_EXTPIN = 3'h3;
	localparam logic [2:0] SRC_MFGROUP = 3'h4;
	// ==========================================================
	// Event widths
	localparam int SER_NCOND = 6;
	localparam int TW_NEV = 3;
	localparam int DM_NEV = 2;
	localparam int MF_N = 4;
	// ==========================================================
	// Reset values
	localparam logic GIE_RST = 1'b0;
	localparam logic [PWK_NSRC-1:0] FLAGS_RST = 5'h00;
	localparam logic [MF_N-1:0] MF_FLAGS_RST = 4'h0;
	localparam logic [1:0] RST_SYNC_RST = 2'h0;
	typedef logic [PWK_NSRC-1:0] pwk_src_vec_t;
endpackage

// *** pwk_ser_if.sv ***
// Interface between the serial condition pulse generator and the controller.
`timescale 1ns/10ps
interface pwk_ser_if;
	logic [pwk_pkg::SER_NCOND-1:0] cond;
	logic req_b;
	modport gen (input cond, output req_b);
	modport ctl (output cond, input req_b);
endinterface

// *** pwk_ser_pulse.sv ***
// Serial port request pulse generator: one low cycle for each cycle in which any condition newly rises.
`timescale 1ns/10ps
module pwk_ser_pulse (
	input wire logic clk_i,
	input wire logic rst_n_i,
	pwk_ser_if.gen ser
);
	import pwk_pkg::*;

	logic [SER_NCOND-1:0] cond_q;
	logic req_b_q;

	// ==========================================================
	// Pulse generation
	// A pulse rather than a level lets a second condition be seen while a first still holds.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cond_q <= '0;
			req_b_q <= 1'b1;
		end else begin
			cond_q <= ser.cond;
			req_b_q <= ~|(ser.cond & ~cond_q);
		end
	end
	assign ser.req_b = req_b_q;

	// ==========================================================
	// Checks
	chk_ser_pulse_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		|(ser.cond & ~cond_q) |=> !ser.req_b) else $error("serial pulse missing");
	chk_ser_pulse_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!ser.req_b |-> $past(|(ser.cond & ~cond_q))) else $error("spurious serial pulse");
endmodule

// *** pwk_top.sv ***
// Peripheral interrupt request, vectoring and wake-up controller.
// How it works
// - Serial request raised by any of six serial conditions.
// - Serial side signals the controller with a one-cycle low pulse.
// - Serial vectors only with global enable, serial enable, stack not full.
// - Serial service clears serial flag and global enable.
// - Serial status flags untouched by service; serial port clears them.
// - Two-wire flag set on byte done, address match or time-out.
// - Two-wire vectors when enabled, stack free; service clears flag, global enable.
// - Data-memory flag set when erase or write cycle completes.
// - Data-memory vectors when enabled, stack free; service clears flag, enable.
// - In low power, any source flag rising wakes the device, source enables ignored.
// - Pin and supply events still set flags and wake in low power.
// - Flags hold until serviced or cleared; source enables only block service, member enables also block group flag set.
// - Service clears group flag only; software clears member flags.
// - Only the program counter push is requested on entry.
// - Interrupt return sets global enable; plain return leaves it cleared.
`timescale 1ns/10ps
module pwk_top (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic [pwk_pkg::SER_NCOND-1:0] serial_status_flags_i,
	input wire logic [pwk_pkg::TW_NEV-1:0] twowire_event_i,
	input wire logic [pwk_pkg::DM_NEV-1:0] datamem_event_i,
	input wire logic ext_pin_i,
	input wire logic [pwk_pkg::MF_N-1:0] mf_event_i,
	input wire logic [pwk_pkg::MF_N-1:0] mf_enable_i,
	input wire logic [pwk_pkg::MF_N-1:0] mf_clr_i,
	input wire logic [pwk_pkg::PWK_NSRC-1:0] irq_enable_i,
	input wire logic [pwk_pkg::PWK_NSRC-1:0] flag_set_i,
	input wire logic [pwk_pkg::PWK_NSRC-1:0] flag_clr_i,
	input wire logic gie_set_i,
	input wire logic gie_clr_i,
	input wire logic core_ready_i,
	input wire logic stack_full_i,
	input wire logic return_restore_gie_i,
	input wire logic plain_return_i,
	input wire logic low_power_i,
	output logic vec_valid_o,
	output logic [pwk_pkg::PWK_IDXW-1:0] vec_idx_o,
	output logic push_pc_o,
	output logic global_irq_enable_o,
	output logic [pwk_pkg::PWK_NSRC-1:0] irq_flags_o,
	output logic [pwk_pkg::MF_N-1:0] mf_flags_o,
	output logic wake_o
);
	import pwk_pkg::*;

	// ==========================================================
	// Functions
	function automatic pwk_src_vec_t low_mask(input logic [PWK_IDXW-1:0] idx);
		low_mask = ~({PWK_NSRC{1'b1}} << idx);
	endfunction

	function automatic logic [PWK_IDXW-1:0] pick_first(input pwk_src_vec_t v);
		pick_first = '0;
		for (int i = PWK_NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				pick_first = PWK_IDXW'(i);
			end
		end
	endfunction

	// ==========================================================
	// Reset and pin synchronisers
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [2:0] pin_sync_q;
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_sync_q <= RST_SYNC_RST;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// The pin edge is taken from stages two and three, never from the first stage.
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_sync_q <= 3'h0;
		end else begin
			pin_sync_q <= {pin_sync_q[1:0], ext_pin_i};
		end
	end

	// ==========================================================
	// Serial pulse generator
	pwk_ser_if ser_if ();
	assign ser_if.cond = serial_status_flags_i;
	pwk_ser_pulse u_ser (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.ser(ser_if.gen)
	);

	// ==========================================================
	// Flag set and clear terms
	pwk_src_vec_t flags_q;
	pwk_src_vec_t flags_d;
	pwk_src_vec_t set_c;
	pwk_src_vec_t clr_c;
	pwk_src_vec_t pend_c;
	pwk_src_vec_t svc_clr_c;
	logic [MF_N-1:0] mf_flags_q;
	logic gie_q;
	logic vec_valid_q;
	logic [PWK_IDXW-1:0] vec_idx_q;
	logic push_pc_q;
	logic wake_q;
	logic take_c;
	logic [PWK_IDXW-1:0] pick_c;

	always_comb begin
		set_c = flag_set_i;
		set_c[SRC_SERIAL] = flag_set_i[SRC_SERIAL] | ~ser_if.req_b;
		set_c[SRC_TWOWIRE] = flag_set_i[SRC_TWOWIRE] | (|twowire_event_i);
		set_c[SRC_DATAMEM] = flag_set_i[SRC_DATAMEM] | (|datamem_event_i);
		// Flags sample on the system clock, so that clock must keep running in low power.
		set_c[SRC_EXTPIN] = flag_set_i[SRC_EXTPIN] | (pin_sync_q[1] & ~pin_sync_q[2]);
		set_c[SRC_MFGROUP] = flag_set_i[SRC_MFGROUP] | (|(mf_event_i & mf_enable_i));
	end

	assign pend_c = flags_q & irq_enable_i;
	assign take_c = core_ready_i & gie_q & ~stack_full_i & (|pend_c);
	assign pick_c = pick_first(pend_c);
	assign svc_clr_c = take_c ? (~low_mask(pick_c) & low_mask(pick_c + 3'h1)) : '0;
	assign clr_c = flag_clr_i | svc_clr_c;
	// A set in the same cycle as a clear wins.
	assign flags_d = set_c | (flags_q & ~clr_c);

	// ==========================================================
	// Flag registers
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= FLAGS_RST;
		end else begin
			flags_q <= flags_d;
		end
	end

	// Member flags are left alone by service and fall only on their own clear.
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mf_flags_q <= MF_FLAGS_RST;
		end else begin
			mf_flags_q <= mf_event_i | (mf_flags_q & ~mf_clr_i);
		end
	end

	// ==========================================================
	// Global enable
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			gie_q <= GIE_RST;
		end else if (return_restore_gie_i || gie_set_i) begin
			gie_q <= 1'b1;
		end else if (take_c || gie_clr_i) begin
			gie_q <= 1'b0;
		end
	end

	// ==========================================================
	// Vectoring
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			vec_valid_q <= 1'b0;
			vec_idx_q <= '0;
			push_pc_q <= 1'b0;
		end else begin
			vec_valid_q <= take_c;
			push_pc_q <= take_c;
			if (take_c) begin
				vec_idx_q <= pick_c;
			end
		end
	end

	// ==========================================================
	// Wake-up
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= low_power_i & (|(flags_d & ~flags_q));
		end
	end

	assign vec_valid_o = vec_valid_q;
	assign vec_idx_o = vec_idx_q;
	assign push_pc_o = push_pc_q;
	assign global_irq_enable_o = gie_q;
	assign irq_flags_o = flags_q;
	assign mf_flags_o = mf_flags_q;
	assign wake_o = wake_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n);

	chk_vec_gating: assert property (vec_valid_q |->
		$past(gie_q) && !$past(stack_full_i) && $past(core_ready_i))
		else $error("vector without enable or with full stack");
	chk_svc_gie_clear: assert property (vec_valid_q && !$past(gie_set_i)
		&& !$past(return_restore_gie_i) |-> !gie_q)
		else $error("global enable not cleared on service");
	// The index is read now and the pending word one cycle back, since the index moves on take.
	chk_vec_enabled: assert property (vec_valid_q |->
		|($past(pend_c) & (pwk_src_vec_t'(1) << vec_idx_q)))
		else $error("vector to a source not pending and enabled");
	chk_flag_hold: assert property (($past(flags_q) & ~flags_q & ~$past(clr_c)) == '0)
		else $error("flag fell without a clear");
	chk_serial_set: assert property (!ser_if.req_b |=> flags_q[SRC_SERIAL])
		else $error("serial flag not set by pulse");
	chk_twowire_set: assert property (|twowire_event_i |=> flags_q[SRC_TWOWIRE])
		else $error("two-wire flag not set");
	chk_datamem_set: assert property (|datamem_event_i |=> flags_q[SRC_DATAMEM])
		else $error("data-memory flag not set");
	chk_wake_rise: assert property (low_power_i && |(set_c & ~flags_q) |=> wake_q)
		else $error("no wake on flag rise");
	chk_return_restore_gie_gie: assert property (return_restore_gie_i |=> gie_q ##1 1'b1)
		else $error("interrupt return left enable low");
	chk_ret_keeps: assert property (plain_return_i && !gie_q && !gie_set_i
		&& !return_restore_gie_i |=> !gie_q)
		else $error("plain return raised enable");
	chk_mf_members: assert property (($past(mf_flags_q) & ~mf_flags_q & ~$past(mf_clr_i)) == '0)
		else $error("member flag fell without software clear");
	chk_priority: assert property (vec_valid_q |->
		($past(pend_c) & low_mask(vec_idx_q)) == '0)
		else $error("lower index pending but not chosen");
	chk_push_pair: assert property (push_pc_q |-> vec_valid_q ##1 !push_pc_q)
		else $error("push not paired with a single vector");

	cov_serial_vec: cover property (vec_valid_q && vec_idx_q == SRC_SERIAL);
	cov_two_pending: cover property (take_c && $countones(pend_c) > 1);
	cov_wake: cover property (wake_q);
	cov_return_restore_gie_after_vec: cover property (vec_valid_q ##[1:20] return_restore_gie_i);
endmodule

// *** pwk_core_model.sv ***
// Behavioural core sequencer that takes vectors and later returns from them.
`timescale 1ns/10ps
module pwk_core_model (
	input wire logic clk_i,
	input wire logic vec_valid_i,
	input wire logic plain_i,
	output logic core_ready_o,
	output logic return_restore_gie_o,
	output logic ret_o
);
	logic busy_q;
	logic [1:0] cnt_q;
	// ==========================================================
	// Handler
	// The handler never makes a nested call, so one stack level is enough.
	initial begin
		busy_q = 1'b0;
		cnt_q = 2'h0;
		return_restore_gie_o = 1'b0;
		ret_o = 1'b0;
	end
	assign core_ready_o = !busy_q;
	always @(posedge clk_i) begin
		return_restore_gie_o <= 1'b0;
		ret_o <= 1'b0;
		if (vec_valid_i) begin
			busy_q <= 1'b1;
			cnt_q <= 2'h3;
		end else if (busy_q) begin
			cnt_q <= cnt_q - 2'h1;
			if (cnt_q == 2'h0) begin
				busy_q <= 1'b0;
				return_restore_gie_o <= !plain_i;
				ret_o <= plain_i;
			end
		end
	end
endmodule

// *** tb_top.sv ***
// Testbench for the peripheral interrupt and wake-up controller.
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [5:0] ser = 6'h00;
	logic [2:0] tw = 3'h0;
	logic [1:0] dm = 2'h0;
	logic [3:0] mfe = 4'h0;
	logic [3:0] mfen = 4'h0;
	logic [3:0] mfc = 4'h0;
	logic [4:0] en = 5'h00;
	logic [4:0] fs = 5'h00;
	logic [4:0] fc = 5'h00;
	logic ext = 1'b0;
	logic gs = 1'b0;
	logic gc = 1'b0;
	logic sfull = 1'b0;
	logic lp = 1'b0;
	logic plain = 1'b1;
	logic rdy, return_restore_gie, ret, vv, push, gie, wake;
	logic [2:0] idx;
	logic [4:0] fl;
	logic [3:0] mf;
	int mismatches = 0;
	int n_checks = 0;
	int cycles = 0;
	always #2.5 clk = ~clk;
	pwk_core_model core (.clk_i(clk), .vec_valid_i(vv), .plain_i(plain),
		.core_ready_o(rdy), .return_restore_gie_o(return_restore_gie), .ret_o(ret));
	pwk_top dut (.ref_clk_i(clk), .rst_b_i(rst_b), .serial_status_flags_i(ser),
		.twowire_event_i(tw), .datamem_event_i(dm), .ext_pin_i(ext), .mf_event_i(mfe),
		.mf_enable_i(mfen), .mf_clr_i(mfc), .irq_enable_i(en), .flag_set_i(fs),
		.flag_clr_i(fc), .gie_set_i(gs), .gie_clr_i(gc), .core_ready_i(rdy),
		.stack_full_i(sfull), .return_restore_gie_i(return_restore_gie), .plain_return_i(ret),
		.low_power_i(lp), .vec_valid_o(vv), .vec_idx_o(idx), .push_pc_o(push),
		.global_irq_enable_o(gie), .irq_flags_o(fl), .mf_flags_o(mf), .wake_o(wake));
	// ==========================================================
	// Helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask
	task automatic gset;
		gs = 1'b1;
		cyc(1);
		gs = 1'b0;
	endtask
	task automatic wvec(input logic [2:0] i);
		int n;
		n = 0;
		while (vv !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		chk(vv === 1'b1 && push === 1'b1 && idx === i && gie === 1'b0, "vector");
	endtask
	task automatic wwake(input logic exp, input string m);
		logic seen;
		seen = 1'b0;
		repeat (8) begin
			cyc(1);
			seen = seen | (wake === 1'b1);
		end
		chk(seen === exp, m);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_serial;
		en = 5'h01;
		for (int b = 0; b < 6; b++) begin
			ser = 6'h01 << b;
			cyc(4);
			chk(fl[0] === 1'b1, "serial flag");
			gset();
			wvec(3'h0);
			cyc(3);
			chk(fl[0] === 1'b0, "serial flag set again");
			ser = 6'h00;
		end
		$display("test serial done");
	endtask
	task automatic t_twowire;
		en = 5'h02;
		for (int b = 0; b < 3; b++) begin
			tw = 3'h1 << b;
			cyc(1);
			tw = 3'h0;
			cyc(2);
			chk(fl[1] === 1'b1, "twowire flag");
			gset();
			wvec(3'h1);
		end
		$display("test twowire done");
	endtask
	task automatic t_datamem;
		for (int b = 0; b < 2; b++) begin
			en = 5'h00;
			dm = 2'h1 << b;
			cyc(1);
			dm = 2'h0;
			gset();
			sfull = 1'b1;
			cyc(5);
			chk(fl[2] === 1'b1 && gie === 1'b1, "disabled source taken");
			en = 5'h04;
			cyc(5);
			chk(fl[2] === 1'b1 && gie === 1'b1, "taken with stack full");
			sfull = 1'b0;
			wvec(3'h2);
		end
		$display("test datamem done");
	endtask
	task automatic t_prio;
		en = 5'h06;
		fs = 5'h06;
		cyc(1);
		fs = 5'h00;
		gset();
		wvec(3'h1);
		chk(fl[2] === 1'b1, "lower request lost");
		gset();
		wvec(3'h2);
		$display("test priority done");
	endtask
	task automatic t_group;
		en = 5'h10;
		mfen = 4'h1;
		mfe = 4'h1;
		cyc(1);
		mfe = 4'h0;
		cyc(2);
		chk(mf[0] === 1'b1 && fl[4] === 1'b1, "group flags");
		gset();
		wvec(3'h4);
		chk(mf[0] === 1'b1, "member flag lost");
		mfc = 4'h1;
		cyc(1);
		mfc = 4'h0;
		cyc(1);
		chk(mf[0] === 1'b0, "member flag kept");
		$display("test group done");
	endtask
	task automatic t_wake;
		en = 5'h00;
		lp = 1'b1;
		ext = 1'b1;
		wwake(1'b1, "pin wake");
		chk(fl[3] === 1'b1, "pin flag");
		fs = 5'h10;
		wwake(1'b1, "flag wake");
		fs = 5'h00;
		ext = 1'b0;
		cyc(3);
		ext = 1'b1;
		wwake(1'b0, "wake from preset flag");
		fc = 5'h18;
		cyc(1);
		fc = 5'h00;
		cyc(1);
		chk(fl === 5'h00, "software clear");
		lp = 1'b0;
		$display("test wake done");
	endtask
	task automatic t_return;
		en = 5'h02;
		plain = 1'b0;
		fs = 5'h02;
		cyc(1);
		fs = 5'h00;
		gset();
		wvec(3'h1);
		cyc(8);
		chk(gie === 1'b1, "enable not restored");
		plain = 1'b1;
		fs = 5'h02;
		cyc(1);
		fs = 5'h00;
		wvec(3'h1);
		cyc(8);
		chk(gie === 1'b0, "enable set by plain return");
		gset();
		chk(gie === 1'b1, "software set of enable");
		gc = 1'b1;
		cyc(1);
		gc = 1'b0;
		chk(gie === 1'b0, "software clear of enable");
		$display("test return done");
	endtask
	// ==========================================================
	// Run control
	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			$display("Error at %0t: timeout", $time);
			end_of_test();
		end
	end
	initial begin
		cyc(8);
		rst_b = 1'b1;
		cyc(4);
		t_serial();
		t_twowire();
		t_datamem();
		t_prio();
		t_group();
		t_wake();
		t_return();
		end_of_test();
	end
endmodule
